/* reload_timers_pkg.sv */
// Package: register map, field layout and types for the reload timers
package reload_timers_pkg;

    // Register offsets (printed offsets are not all multiples of four,
    // so each is a register index; byte address is four times it)
    localparam logic [15:0] TIMER_FOUR_COUNT_LOW_IDX   = 16'h00ac;
    localparam logic [15:0] TIMER_FOUR_COUNT_HIGH_IDX  = 16'h00ad;
    localparam logic [15:0] TIMER_THREE_COUNT_LOW_IDX  = 16'h00ae;
    localparam logic [15:0] TIMER_THREE_COUNT_HIGH_IDX = 16'h00af;
    localparam logic [15:0] TIMERS_THREE_FOUR_CTRL_IDX = 16'h00cf;
    localparam logic [15:0] TIMER_FIVE_COUNT_HIGH_IDX  = 16'ha063;
    localparam logic [15:0] TIMER_FIVE_CONTROL_IDX     = 16'ha068;
    localparam logic [15:0] TIMER_FIVE_COUNT_LOW_IDX   = 16'ha069;
    localparam logic [15:0] TIMER_FIVE_COUNT_MID_IDX   = 16'ha06a;

    // Bit positions inside each four-bit group of the shared control
    localparam int GRP_FLAG = 3;
    localparam int GRP_MODE = 2;
    localparam int GRP_RUN  = 1;
    localparam int GRP_IEN  = 0;

    // Timer five control field positions
    localparam int T5_FLAG    = 7;
    localparam int T5_SEL_HI  = 6;
    localparam int T5_SEL_LO  = 5;
    localparam int T5_MODE    = 4;
    localparam int T5_RUN     = 3;
    localparam int T5_IEN     = 0;

    // Reset values
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [15:0] COUNT16_RST = 16'h0000;
    localparam logic [23:0] COUNT24_RST = 24'h000000;

    // One timer group's control bits
    typedef struct packed {
        logic flag;
        logic reload_select;
        logic run;
        logic irq_enable;
    } timer_ctrl_t;

    // Timer five control bits
    typedef struct packed {
        logic       flag;
        logic [1:0] clock_select;
        logic       reload_select;
        logic       run;
        logic       irq_enable;
    } timer5_ctrl_t;

endpackage

/* reload_timers_three_four_five.sv */
// Reload timers three, four (16 bit) and five (24 bit) with APB access
// Operation
// - Timers three and four are 16-bit counters on the system clock.
// - Shared control: timer four bits 7-4, timer three bits 3-0.
// - Timer three/four overflow sets flag; only software clears it.
// - Mode bit 1 selects auto-reload, 0 free-running, timers three/four.
// - Timers three/four count only while run bit set; clear holds value.
// - Timer three/four interrupt request passes only when enable is 1.
// - Count byte write loads reload byte in reload mode, else counter.
// - Any count byte read returns live counter; no snapshot taken.
// - Timer five is a 24-bit counter in low, middle, high bytes.
// - Timer five select 00/01 fast oscillator, 10/11 slow 32k clock.
// - Timer five counts source ticks on the system clock; clock enable low freezes it.
// - Timer five overflow sets bit 7 flag; only software clears it.
// - Timer five bit 4 selects auto-reload when 1, free-run when 0.
// - Timer five counts only while bit 3 run is set.
// - Timer five interrupt request passes only while bit 0 is 1.
// - Timer five count byte write: reload byte or live counter byte.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps

module reload_timers_three_four_five (
    // Clock, reset and enable
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        clk_en_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [17:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Timer five tick sources, synchronous one-cycle enables
    input  wire logic        fast_osc_tick_i,
    input  wire logic        slow_32k_tick_i,
    // Gated overflow interrupt requests
    output logic             timer_three_irq_o,
    output logic             timer_four_irq_o,
    output logic             timer_five_irq_o
);

    // Control state
    reload_timers_pkg::timer_ctrl_t  ctrl_three;
    reload_timers_pkg::timer_ctrl_t  ctrl_four;
    reload_timers_pkg::timer5_ctrl_t ctrl_five;

    // Counters and reload registers
    logic [15:0] count_three;
    logic [15:0] count_four;
    logic [23:0] count_five;
    logic [15:0] reload_three;
    logic [15:0] reload_four;
    logic [23:0] reload_five;

    // APB decode
    wire        access   = psel_i & penable_i;
    wire        wr_en    = access & pwrite_i & pstrb_i[0];
    wire [15:0] word_idx = paddr_i[17:2];
    wire        hit_t4l  = word_idx
                          == reload_timers_pkg::TIMER_FOUR_COUNT_LOW_IDX;
    wire        hit_t4h  = word_idx
                          == reload_timers_pkg::TIMER_FOUR_COUNT_HIGH_IDX;
    wire        hit_t3l  = word_idx
                          == reload_timers_pkg::TIMER_THREE_COUNT_LOW_IDX;
    wire        hit_t3h  = word_idx
                          == reload_timers_pkg::TIMER_THREE_COUNT_HIGH_IDX;
    wire        hit_c34  = word_idx
                          == reload_timers_pkg::TIMERS_THREE_FOUR_CTRL_IDX;
    wire        hit_t5h  = word_idx
                          == reload_timers_pkg::TIMER_FIVE_COUNT_HIGH_IDX;
    wire        hit_c5   = word_idx
                          == reload_timers_pkg::TIMER_FIVE_CONTROL_IDX;
    wire        hit_t5l  = word_idx
                          == reload_timers_pkg::TIMER_FIVE_COUNT_LOW_IDX;
    wire        hit_t5m  = word_idx
                          == reload_timers_pkg::TIMER_FIVE_COUNT_MID_IDX;
    wire        hit_any  = hit_t4l | hit_t4h | hit_t3l | hit_t3h | hit_c34
                         | hit_t5h | hit_c5 | hit_t5l | hit_t5m;
    wire        misalign = paddr_i[1:0] != 2'h0;
    wire [7:0]  wbyte    = pwdata_i[7:0];

    // Zero-wait slave; unmapped or misaligned answer an error
    assign pready_o  = 1'b1;
    assign pslverr_o = access & (~hit_any | misalign);
    wire   wr_ok     = wr_en & ~misalign & clk_en_i;

    // Tick steering for timer five
    wire t5_tick = ctrl_five.clock_select[1] ? slow_32k_tick_i
                                             : fast_osc_tick_i;

    // Count enables and overflow detection
    wire inc_three = clk_en_i & ctrl_three.run;
    wire inc_four  = clk_en_i & ctrl_four.run;
    wire inc_five  = clk_en_i & ctrl_five.run & t5_tick;
    wire ovf_three = inc_three & (&count_three);
    wire ovf_four  = inc_four  & (&count_four);
    wire ovf_five  = inc_five  & (&count_five);

    // Byte write strobes into counter or reload
    wire w3l = wr_ok & hit_t3l;
    wire w3h = wr_ok & hit_t3h;
    wire w4l = wr_ok & hit_t4l;
    wire w4h = wr_ok & hit_t4h;
    wire w5l = wr_ok & hit_t5l;
    wire w5m = wr_ok & hit_t5m;
    wire w5h = wr_ok & hit_t5h;

    // Next values of timer three
    logic [15:0] next_count_three;
    logic [15:0] next_reload_three;
    always_comb begin
        next_count_three  = count_three;
        next_reload_three = reload_three;
        if (ovf_three) begin
            next_count_three = ctrl_three.reload_select
                ? reload_three : reload_timers_pkg::COUNT16_RST;
        end else if (inc_three) begin
            next_count_three = count_three + 16'h0001;
        end
        if (ctrl_three.reload_select) begin
            if (w3l) next_reload_three[7:0]  = wbyte;
            if (w3h) next_reload_three[15:8] = wbyte;
        end else begin
            if (w3l) next_count_three[7:0]  = wbyte;
            if (w3h) next_count_three[15:8] = wbyte;
        end
    end

    // Next values of timer four
    logic [15:0] next_count_four;
    logic [15:0] next_reload_four;
    always_comb begin
        next_count_four  = count_four;
        next_reload_four = reload_four;
        if (ovf_four) begin
            next_count_four = ctrl_four.reload_select
                ? reload_four : reload_timers_pkg::COUNT16_RST;
        end else if (inc_four) begin
            next_count_four = count_four + 16'h0001;
        end
        if (ctrl_four.reload_select) begin
            if (w4l) next_reload_four[7:0]  = wbyte;
            if (w4h) next_reload_four[15:8] = wbyte;
        end else begin
            if (w4l) next_count_four[7:0]  = wbyte;
            if (w4h) next_count_four[15:8] = wbyte;
        end
    end

    // Next values of timer five
    logic [23:0] next_count_five;
    logic [23:0] next_reload_five;
    always_comb begin
        next_count_five  = count_five;
        next_reload_five = reload_five;
        if (ovf_five) begin
            next_count_five = ctrl_five.reload_select
                ? reload_five : reload_timers_pkg::COUNT24_RST;
        end else if (inc_five) begin
            next_count_five = count_five + 24'h000001;
        end
        if (ctrl_five.reload_select) begin
            if (w5l) next_reload_five[7:0]   = wbyte;
            if (w5m) next_reload_five[15:8]  = wbyte;
            if (w5h) next_reload_five[23:16] = wbyte;
        end else begin
            if (w5l) next_count_five[7:0]   = wbyte;
            if (w5m) next_count_five[15:8]  = wbyte;
            if (w5h) next_count_five[23:16] = wbyte;
        end
    end

    // Control writes; hardware set of a flag wins over software clear
    reload_timers_pkg::timer_ctrl_t  next_ctrl_three;
    reload_timers_pkg::timer_ctrl_t  next_ctrl_four;
    reload_timers_pkg::timer5_ctrl_t next_ctrl_five;
    always_comb begin
        next_ctrl_three = ctrl_three;
        next_ctrl_four  = ctrl_four;
        next_ctrl_five  = ctrl_five;
        if (wr_ok & hit_c34) begin
            next_ctrl_four  = wbyte[7:4];
            next_ctrl_three = wbyte[3:0];
        end
        if (wr_ok & hit_c5) begin
            next_ctrl_five.flag          = wbyte[reload_timers_pkg::T5_FLAG];
            next_ctrl_five.clock_select  =
                wbyte[reload_timers_pkg::T5_SEL_HI:reload_timers_pkg::T5_SEL_LO];
            next_ctrl_five.reload_select = wbyte[reload_timers_pkg::T5_MODE];
            next_ctrl_five.run           = wbyte[reload_timers_pkg::T5_RUN];
            next_ctrl_five.irq_enable    = wbyte[reload_timers_pkg::T5_IEN];
        end
        if (ovf_three) next_ctrl_three.flag = 1'b1;
        if (ovf_four)  next_ctrl_four.flag  = 1'b1;
        if (ovf_five)  next_ctrl_five.flag  = 1'b1;
    end

    // State registers; clock enable freezes everything
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_three   <= '0;
            ctrl_four    <= '0;
            ctrl_five    <= '0;
            count_three  <= reload_timers_pkg::COUNT16_RST;
            count_four   <= reload_timers_pkg::COUNT16_RST;
            count_five   <= reload_timers_pkg::COUNT24_RST;
            reload_three <= reload_timers_pkg::COUNT16_RST;
            reload_four  <= reload_timers_pkg::COUNT16_RST;
            reload_five  <= reload_timers_pkg::COUNT24_RST;
        end else if (clk_en_i) begin
            ctrl_three   <= next_ctrl_three;
            ctrl_four    <= next_ctrl_four;
            ctrl_five    <= next_ctrl_five;
            count_three  <= next_count_three;
            count_four   <= next_count_four;
            count_five   <= next_count_five;
            reload_three <= next_reload_three;
            reload_four  <= next_reload_four;
            reload_five  <= next_reload_five;
        end
    end

    // Read mux: live counters, no snapshot of sibling bytes
    wire [7:0] c5_read = {ctrl_five.flag, ctrl_five.clock_select,
                          ctrl_five.reload_select, ctrl_five.run,
                          2'h0, ctrl_five.irq_enable};
    logic [7:0] rd_byte;
    always_comb begin
        if (hit_t4l)      rd_byte = count_four[7:0];
        else if (hit_t4h) rd_byte = count_four[15:8];
        else if (hit_t3l) rd_byte = count_three[7:0];
        else if (hit_t3h) rd_byte = count_three[15:8];
        else if (hit_c34) rd_byte = {ctrl_four, ctrl_three};
        else if (hit_c5)  rd_byte = c5_read;
        else if (hit_t5l) rd_byte = count_five[7:0];
        else if (hit_t5m) rd_byte = count_five[15:8];
        else if (hit_t5h) rd_byte = count_five[23:16];
        else              rd_byte = 8'h00;
    end
    assign prdata_o = {24'h000000, rd_byte};

    // Interrupt requests follow the sticky flags, gated by enables
    assign timer_three_irq_o = ctrl_three.flag & ctrl_three.irq_enable;
    assign timer_four_irq_o  = ctrl_four.flag  & ctrl_four.irq_enable;
    assign timer_five_irq_o  = ctrl_five.flag  & ctrl_five.irq_enable;

endmodule

/* reload_timers_assertions.sv */
// Port-level assertions for the reload timers
`timescale 1ns/1ps
module reload_timers_checker (
    // Clock and reset
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    // Bus side
    input wire logic        clk_en_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [17:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    // Interrupt requests
    input wire logic        timer_three_irq_o,
    input wire logic        timer_four_irq_o,
    input wire logic        timer_five_irq_o
);
    // Accepted writes only; frozen writes must not excuse a change
    wire wr_go = psel_i & penable_i & pwrite_i & clk_en_i & pstrb_i[0];
    wire wr34  = wr_go & (paddr_i ==
        {reload_timers_pkg::TIMERS_THREE_FOUR_CTRL_IDX, 2'b00});
    wire wr5   = wr_go & (paddr_i ==
        {reload_timers_pkg::TIMER_FIVE_CONTROL_IDX, 2'b00});

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Zero wait states, byte-wide data
    ready_now_a: assert property (psel_i && penable_i |-> pready_o)
        else $error("pready low in access phase");
    upper_zero_a: assert property (prdata_o[31:8] == 24'h000000)
        else $error("read data above bit 7 not zero");
    // Enable bit gates the request
    ien3_off_a: assert property (wr34 && !pwdata_i[0] |=> !timer_three_irq_o)
        else $error("timer three request passed while disabled");
    ien4_off_a: assert property (wr34 && !pwdata_i[4] |=> !timer_four_irq_o)
        else $error("timer four request passed while disabled");
    ien5_off_a: assert property (wr5 && !pwdata_i[0] |=> !timer_five_irq_o)
        else $error("timer five request passed while disabled");
    // Only software clears a flag
    flag3_hold_a: assert property (timer_three_irq_o && !wr34 |=> timer_three_irq_o)
        else $error("timer three flag cleared by hardware");
    flag4_hold_a: assert property (timer_four_irq_o && !wr34 |=> timer_four_irq_o)
        else $error("timer four flag cleared by hardware");
    flag5_hold_a: assert property (timer_five_irq_o && !wr5 |=> timer_five_irq_o)
        else $error("timer five flag cleared by hardware");
endmodule

bind reload_timers_three_four_five reload_timers_checker u_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o),
    .timer_three_irq_o(timer_three_irq_o),
    .timer_four_irq_o(timer_four_irq_o),
    .timer_five_irq_o(timer_five_irq_o));

/* tb_reload_timers_three_four_five.sv */
// Self-checking bench for the reload timers
`timescale 1ns/1ps
module tb_reload_timers_three_four_five;
    logic        core_clk_i, rst_n_i, clk_en_i, psel_i, penable_i, pwrite_i;
    logic [17:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [3:0]  pstrb_i;
    logic        pready_o, pslverr_o, fast_osc_tick_i, slow_32k_tick_i;
    logic        timer_three_irq_o, timer_four_irq_o, timer_five_irq_o;
    logic        fast_on, slow_on, err;
    int          mismatches, total_checks;
    // Register indices
    localparam logic [15:0] ctl34 = reload_timers_pkg::TIMERS_THREE_FOUR_CTRL_IDX;
    localparam logic [15:0] ctl5 = reload_timers_pkg::TIMER_FIVE_CONTROL_IDX;
    localparam logic [15:0] t3l = reload_timers_pkg::TIMER_THREE_COUNT_LOW_IDX;
    localparam logic [15:0] t3h = reload_timers_pkg::TIMER_THREE_COUNT_HIGH_IDX;
    localparam logic [15:0] t4l = reload_timers_pkg::TIMER_FOUR_COUNT_LOW_IDX;
    localparam logic [15:0] t4h = reload_timers_pkg::TIMER_FOUR_COUNT_HIGH_IDX;
    localparam logic [15:0] t5l = reload_timers_pkg::TIMER_FIVE_COUNT_LOW_IDX;
    localparam logic [15:0] t5m = reload_timers_pkg::TIMER_FIVE_COUNT_MID_IDX;
    localparam logic [15:0] t5h = reload_timers_pkg::TIMER_FIVE_COUNT_HIGH_IDX;

    reload_timers_three_four_five u_dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .fast_osc_tick_i(fast_osc_tick_i),
        .slow_32k_tick_i(slow_32k_tick_i),
        .timer_three_irq_o(timer_three_irq_o),
        .timer_four_irq_o(timer_four_irq_o),
        .timer_five_irq_o(timer_five_irq_o));

    // Clock and source ticks every other cycle while a source is on
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        fast_osc_tick_i <= fast_on & ~fast_osc_tick_i;
        slow_32k_tick_i <= slow_on & ~slow_32k_tick_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] idx,
                       input logic [7:0] d);
        @(posedge core_clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= {idx, 2'b00};
        pwdata_i  <= {24'h000000, d};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask

    task automatic s_reset();
        logic [15:0] map [9];
        map = '{t4l, t4h, t3l, t3h, ctl34, t5h, ctl5, t5l, t5m};
        foreach (map[i]) begin
            rdchk(map[i], 32'h0);
        end
        rdchk(16'h00b0, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask
    task automatic s_free();
        wr(t3h, 8'hff);
        wr(t3l, 8'hf0);
        repeat (4) @(posedge core_clk_i);
        rdchk(t3l, 32'hf0);
        wr(ctl34, 8'h02);
        repeat (30) @(posedge core_clk_i);
        chk({31'h0, timer_three_irq_o}, 32'h0);
        rdchk(ctl34, 32'h0a);
        rdchk(t3h, 32'h00);
        wr(ctl34, 8'h0b);
        #1 chk({31'h0, timer_three_irq_o}, 32'h1);
        wr(ctl34, 8'h01);
        #1 chk({31'h0, timer_three_irq_o}, 32'h0);
    endtask
    task automatic s_reload();
        wr(t4h, 8'hff);
        wr(t4l, 8'hf0);
        wr(ctl34, 8'h40);
        wr(t4l, 8'h80);
        wr(t4h, 8'h12);
        rdchk(t4l, 32'hf0);
        wr(ctl34, 8'h70);
        repeat (30) @(posedge core_clk_i);
        rdchk(t4h, 32'h12);
        chk({31'h0, timer_four_irq_o}, 32'h1);
        rdchk(ctl34, 32'hf0);
        wr(ctl34, 8'h00);
    endtask
    task automatic s_five();
        wr(t5h, 8'hff);
        wr(t5m, 8'hff);
        wr(t5l, 8'hf8);
        slow_on <= 1'b1;
        wr(ctl5, 8'h09);
        repeat (40) @(posedge core_clk_i);
        rdchk(t5l, 32'hf8);
        fast_on <= 1'b1;
        slow_on <= 1'b0;
        repeat (40) @(posedge core_clk_i);
        chk({31'h0, timer_five_irq_o}, 32'h1);
        rdchk(t5h, 32'h00);
        rdchk(ctl5, 32'h89);
        wr(ctl5, 8'h00);
        wr(t5m, 8'hff);
        wr(t5h, 8'hff);
        wr(t5l, 8'hfc);
        wr(ctl5, 8'h50);
        wr(t5h, 8'h12);
        rdchk(t5h, 32'hff);
        rdchk(t5l, 32'hfc);
        fast_on <= 1'b0;
        slow_on <= 1'b1;
        wr(ctl5, 8'h59);
        repeat (40) @(posedge core_clk_i);
        rdchk(t5h, 32'h12);
        rdchk(ctl5, 32'hd9);
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reset, then the scenarios; clock enable stays high throughout
    initial begin
        {rst_n_i, psel_i, penable_i, pwrite_i, fast_on, slow_on} = 6'h00;
        {fast_osc_tick_i, slow_32k_tick_i} = 2'b00;
        {paddr_i, pwdata_i} = 50'h0;
        clk_en_i = 1'b1;
        pstrb_i = 4'h1;
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        s_reset();
        s_free();
        s_reload();
        s_five();
        stop_test();
    end
    // Whole run is a few hundred cycles; this leaves ample margin
    initial begin
        #100us;
        mismatches++;
        stop_test();
    end
endmodule
